//--- dv/anp_link_partner.sv
// Link partner model: sends pages and faults, takes queued pages
module anp_link_partner
(
   input  wire logic        clk,
   input  wire logic        slow,
   input  wire logic [15:0] tx_page,
   input  wire logic        tx_page_pend,
   output logic             page_rx_evt,
   output logic [15:0]      page_rx_word,
   output logic             pd_fault_evt,
   output logic             tx_taken_evt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] taken_q;
   logic [2:0]  wait_q;
   // Quiet lines at start
   initial
   begin
      page_rx_evt = 1'b0;
      page_rx_word = 16'h0000;
      pd_fault_evt = 1'b0;
      tx_taken_evt = 1'b0;
      wait_q = 3'h0;
      taken_q = 16'h0000;
   end
   task send_page(input logic [15:0] w);
      page_rx_word <= w;
      page_rx_evt <= 1'b1;
      @(posedge clk);
      page_rx_evt <= 1'b0;
      page_rx_word <= ~w; // Stale word is not left looking valid
   endtask
   task fault;
      pd_fault_evt <= 1'b1;
      @(posedge clk);
      pd_fault_evt <= 1'b0;
   endtask
   // Take a queued page, late when slow so pending is seen to hold
   always @(posedge clk)
   begin
      wait_q <= tx_page_pend ? wait_q + 3'h1 : 3'h0;
      tx_taken_evt <= 1'b0;
      if (tx_page_pend && !tx_taken_evt && wait_q >= (slow ? 3'h4 : 3'h0))
      begin
         taken_q <= tx_page;
         tx_taken_evt <= 1'b1;
      end
   end
endmodule // anp_link_partner

//--- dv/anp_regs_bench.sv
// Testbench of the next-page register block
`include "anp_defines.vh"
module anp_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_b, hsel, hwrite, an_enable, lp_np_able, pnc, slow;
   logic [31:0] haddr, hwdata, tmp;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   wire         hreadyout, hresp, irq, tx_page_pend, pd_evt, rx_evt, taken_evt;
   wire  [31:0] hrdata;
   wire  [15:0] tx_page, rx_word;
   int          err_total, total_checks;
   anp_regs uut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .an_enable(an_enable), .pd_fault_evt(pd_evt),
      .lp_np_able(lp_np_able), .partner_negotiation_capable(pnc), .page_rx_evt(rx_evt),
      .page_rx_word(rx_word), .tx_taken_evt(taken_evt), .tx_page(tx_page),
      .tx_page_pend(tx_page_pend), .irq(irq));
   anp_link_partner u_lp (.clk(clk), .slow(slow), .tx_page(tx_page), .tx_page_pend(tx_page_pend),
      .page_rx_evt(rx_evt), .page_rx_word(rx_word), .pd_fault_evt(pd_evt), .tx_taken_evt(taken_evt));
   // ************************************************************
   // Clock, tasks
   // ************************************************************
   always #2 clk = ~clk;
   task end_sim;
      if (err_total == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One single transfer; entered just after a rising edge
   task xfer(input logic [5:0] idx, input logic w, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h000000, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1)
         @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1)
         @(posedge clk);
      tmp = hrdata;
   endtask
   task rchk(input string nm, input logic [5:0] idx, input logic [31:0] e);
      xfer(idx, 1'b0, 32'h00000000);
      chk(nm, e, tmp);
   endtask
   // Hang guard
   initial
   begin
      #20000;
      err_total++;
      end_sim;
   end
   // ************************************************************
   // Scenarios
   // ************************************************************
   initial
   begin
      clk = 1'b0;
      rst_b = 1'b0;
      {hsel, hwrite, an_enable, lp_np_able, pnc, slow} = 6'h00;
      {haddr, hwdata} = 64'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      err_total = 0;
      total_checks = 0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      rchk("exp", `ANP_IDX_EXP, 32'h4);
      rchk("nptx", `ANP_IDX_NPTX, 32'h1);
      rchk("nprx", `ANP_IDX_NPRX, 32'h0);
      rchk("unmapped", 6'h0F, 32'h0);
      lp_np_able <= 1'b1;
      pnc <= 1'b1;
      rchk("exp", `ANP_IDX_EXP, 32'hC);
      an_enable <= 1'b1;
      rchk("exp", `ANP_IDX_EXP, 32'hD);
      u_lp.fault;
      rchk("exp", `ANP_IDX_EXP, 32'h1D);
      rchk("exp", `ANP_IDX_EXP, 32'hD);
      u_lp.send_page(16'hFFFF);
      rchk("exp", `ANP_IDX_EXP, 32'hF);
      rchk("exp", `ANP_IDX_EXP, 32'hD);
      rchk("nprx", `ANP_IDX_NPRX, 32'hB7FF);
      rchk("nptx", `ANP_IDX_NPTX, 32'h1);
      u_lp.send_page(16'h0000);
      rchk("nprx", `ANP_IDX_NPRX, 32'h800);
      xfer(`ANP_IDX_NPRX, 1'b1, 32'hFFFF);
      rchk("nprx", `ANP_IDX_NPRX, 32'h800);
      // The second page left the new-page flag set; a write must not clear it
      xfer(`ANP_IDX_EXP, 1'b1, 32'hFFFF);
      rchk("exp", `ANP_IDX_EXP, 32'hF);
      xfer(`ANP_IDX_NPTX, 1'b1, 32'hFFFF);
      rchk("nptx", `ANP_IDX_NPTX, 32'hBFFF);
      repeat (8) @(posedge clk);
      chk("taken", 32'hBFFF, {16'h0000, u_lp.taken_q});
      slow <= 1'b1;
      xfer(`ANP_IDX_NPTX, 1'b1, 32'h4000);
      chk("pend", 32'h1, {31'h0, tx_page_pend});
      rchk("nptx", `ANP_IDX_NPTX, 32'h800);
      repeat (8) @(posedge clk);
      chk("taken", 32'h800, {16'h0000, u_lp.taken_q});
      chk("pend", 32'h0, {31'h0, tx_page_pend});
      xfer(`ANP_IDX_IRQ_STAT, 1'b1, 32'h7);
      rchk("stat", `ANP_IDX_IRQ_STAT, 32'h0);
      xfer(`ANP_IDX_IRQ_MASK, 1'b1, 32'h1);
      rchk("mask", `ANP_IDX_IRQ_MASK, 32'h1);
      u_lp.fault;
      repeat (3) @(posedge clk);
      chk("irq", 32'h1, {31'h0, irq});
      xfer(`ANP_IDX_IRQ_STAT, 1'b1, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq", 32'h0, {31'h0, irq});
      xfer(`ANP_IDX_IRQ_MASK, 1'b1, 32'h0);
      u_lp.fault;
      repeat (3) @(posedge clk);
      chk("irq", 32'h0, {31'h0, irq});
      rchk("stat", `ANP_IDX_IRQ_STAT, 32'h1);
      // Page interrupt arrives one edge after the fault path does
      xfer(`ANP_IDX_IRQ_MASK, 1'b1, 32'h2);
      u_lp.send_page(16'h0000);
      repeat (4) @(posedge clk);
      chk("irq", 32'h1, {31'h0, irq});
      end_sim;
   end
endmodule // anp_regs_bench

//--- dv/anp_regs_sva.sv
// Checker of bus timing and page outputs of the register block
module anp_regs_sva
(
   input wire        clk,
   input wire        rst_b,
   input wire        hsel,
   input wire [1:0]  htrans,
   input wire        hready,
   input wire        hreadyout,
   input wire [31:0] hrdata,
   input wire        hresp,
   input wire        pd_fault_evt,
   input wire        page_rx_evt,
   input wire [15:0] page_rx_word,
   input wire        tx_taken_evt,
   input wire [15:0] tx_page,
   input wire        tx_page_pend,
   input wire        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // Properties
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // Accepted address phase
   wire take_w = hsel && hready && (htrans == 2'h2);
   AST_ONE_WAIT: assert property (take_w |=> !hreadyout ##1 hreadyout)
      else $error("bus answer not after one wait state");
   AST_NO_LONG_WAIT: assert property (!hreadyout |=> hreadyout)
      else $error("wait state longer than one cycle");
   AST_OKAY: assert property (hresp == 1'b0)
      else $error("response not okay");
   AST_UPPER_ZERO: assert property (hreadyout |-> hrdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   AST_TX_RSVD: assert property (tx_page[14] == 1'b0)
      else $error("transmit bit 14 set");
   AST_TOGGLE_LOAD: assert property (page_rx_evt |=> tx_page[11] == !$past(page_rx_word[11]))
      else $error("toggle not inverse of received word");
   AST_TOGGLE_HOLD: assert property ($changed(tx_page[11]) |-> $past(page_rx_evt))
      else $error("toggle changed without a page");
   AST_TX_CAUSE: assert property (!$stable(tx_page) |-> $past(!hreadyout) || $past(page_rx_evt))
      else $error("transmit page changed without cause");
   AST_PEND_SET: assert property ($rose(tx_page_pend) |-> $past(!hreadyout))
      else $error("pending rose without a write");
   AST_PEND_CLR: assert property (tx_taken_evt && hreadyout |=> !tx_page_pend)
      else $error("pending not cleared when taken");
   // A received page reaches the status one edge later than the other events
   AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(pd_fault_evt, 2) || $past(tx_taken_evt, 2)
      || $past(page_rx_evt, 3) || $past(!hreadyout, 2))
      else $error("interrupt rose without an event");
   // Main scenarios reached
   cover property (page_rx_evt);
   cover property (tx_taken_evt);
   cover property ($rose(irq));
endmodule // anp_regs_sva

bind anp_regs anp_regs_sva u_sva (.clk(clk), .rst_b(rst_b), .hsel(hsel), .htrans(htrans),
   .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
   .pd_fault_evt(pd_fault_evt), .page_rx_evt(page_rx_evt), .page_rx_word(page_rx_word),
   .tx_taken_evt(tx_taken_evt), .tx_page(tx_page), .tx_page_pend(tx_page_pend), .irq(irq));

//--- hdl/anp_defines.vh
// Register map, field positions and reset values of the next-page register block
`ifndef ANP_DEFINES_VH
`define ANP_DEFINES_VH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define ANP_IDX_EXP        6'h06
`define ANP_IDX_NPTX       6'h07
`define ANP_IDX_NPRX       6'h08
`define ANP_IDX_IRQ_STAT   6'h10
`define ANP_IDX_IRQ_MASK   6'h11
`define ANP_IDX_W          6

// ************************************************************
// Expansion register fields
// ************************************************************
`define ANP_EXP_PD_FAULT   4
`define ANP_EXP_LP_NP      3
`define ANP_EXP_LOCAL_NP   2
`define ANP_EXP_PAGE_RX    1
`define ANP_EXP_LP_AN      0

// ************************************************************
// Next-page register fields
// ************************************************************
`define ANP_NP_MORE        15
`define ANP_NP_RSVD        14
`define ANP_NP_MSG         13
`define ANP_NP_COMPLY_ACKNOWLEDGE        12
`define ANP_NP_TOGGLE      11
`define ANP_NP_CODE_HI     10
`define ANP_NP_WMASK       16'hB7FF
`define ANP_NPTX_RESET     16'h0001
`define ANP_NPRX_RESET     16'h0000

// ************************************************************
// Interrupt status and mask fields
// ************************************************************
`define ANP_IRQ_PD_FAULT   0
`define ANP_IRQ_PAGE_RX    1
`define ANP_IRQ_TX_TAKEN   2
`define ANP_IRQ_W          3
`define ANP_IRQ_MASK_RESET 3'h0

// ************************************************************
// Bus constants
// ************************************************************
`define ANP_HTRANS_NONSEQ  2'h2
`define ANP_HRESP_OKAY     1'h0

`endif

//--- hdl/anp_regs.v
// Auto-negotiation expansion and next-page registers behind an AHB-Lite slave
`include "anp_defines.vh"

// Notes on behaviour
// - Expansion, transmit, receive at indices 6, 7, 8
// - Bit 4: parallel fault, cleared by read
// - Bit 3: partner next-page ability, read-only
// - Bit 2: local next-page ability, fixed by LOCAL_NP_ABLE, default 1
// - Bit 1: new page received, clear on read
// - Bit 0: partner negotiation capable when enabled
// - Transmit bit 12 is comply acknowledge
// - Bit 11 holds inverse of previous toggle
// - Transmit code field writable, resets to one
// - Receive register shows partner page with toggle bit 11 inverted, read-only
// - Bit 14 of both pages reads zero
module anp_regs
#(
   parameter LOCAL_NP_ABLE = 1'b1
)
(
   input  wire        clk,
   input  wire        rst_b,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire [31:0] hrdata,
   output wire        hresp,
   input  wire        an_enable,
   input  wire        pd_fault_evt,
   input  wire        lp_np_able,
   input  wire        partner_negotiation_capable,
   input  wire        page_rx_evt,
   input  wire [15:0] page_rx_word,
   input  wire        tx_taken_evt,
   output wire [15:0] tx_page,
   output wire        tx_page_pend,
   output wire        irq
);

   // ************************************************************
   // Reset release
   // ************************************************************

   wire rst_n;

   anp_rst_sync u_rst_sync
   (
      .clk        (clk),
      .rst_b      (rst_b),
      .rst_sync_b (rst_n)
   );

   // ************************************************************
   // Address decode helper
   // ************************************************************

   // Word index of a bus address; above-map addresses give no hit
   function [`ANP_IDX_W:0] addr_decode;
      input [31:0] addr;
      begin
         addr_decode = {(addr[31:8] == 24'h000000), addr[7:2]};
      end
   endfunction

   // ************************************************************
   // Bus state
   // ************************************************************

   reg                  dp_q;
   reg                  dp_wr_q;
   reg                  dp_map_q;
   reg [`ANP_IDX_W-1:0] dp_idx_q;
   reg                  hready_q;
   reg [31:0]           hrdata_q;
   reg                  hresp_q;

   wire [`ANP_IDX_W:0]  dec;
   wire                 ap_take;

   assign dec = addr_decode(haddr);

   // Only whole-word single transfers are issued, so size is not checked
   assign ap_take = hsel & hready & (htrans == `ANP_HTRANS_NONSEQ);

   // ************************************************************
   // Register state
   // ************************************************************

   reg [15:0]           nptx_q;
   reg [15:0]           nprx_q;
   reg                  page_dly_q;
   reg                  pend_q;
   reg [`ANP_IRQ_W-1:0] mask_q;
   reg                  irq_q;

   wire [1:0]           exp_flags;
   wire [`ANP_IRQ_W-1:0] irq_stat;

   // Decoded data-phase accesses
   wire                 hit_exp;
   wire                 hit_tx;
   wire                 hit_irq;
   wire                 hit_mask;
   wire                 do_rd;
   wire                 do_wr;

   assign do_rd    = dp_q & ~dp_wr_q & dp_map_q;
   assign do_wr    = dp_q & dp_wr_q & dp_map_q;
   assign hit_exp  = (dp_idx_q == `ANP_IDX_EXP);
   assign hit_tx   = (dp_idx_q == `ANP_IDX_NPTX);
   assign hit_irq  = (dp_idx_q == `ANP_IDX_IRQ_STAT);
   assign hit_mask = (dp_idx_q == `ANP_IDX_IRQ_MASK);

   // ************************************************************
   // Address phase capture and one wait state
   // ************************************************************

   // The registered wait state keeps hrdata straight from a flip-flop
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dp_q     <= 1'b0;
         dp_wr_q  <= 1'b0;
         dp_map_q <= 1'b0;
         dp_idx_q <= {`ANP_IDX_W{1'b0}};
         hready_q <= 1'b1;
         hresp_q  <= `ANP_HRESP_OKAY;
      end
      else if (ap_take)
      begin
         dp_q     <= 1'b1;
         dp_wr_q  <= hwrite;
         dp_map_q <= dec[`ANP_IDX_W];
         dp_idx_q <= dec[`ANP_IDX_W-1:0];
         hready_q <= 1'b0;
      end
      else
      begin
         dp_q     <= 1'b0;
         hready_q <= 1'b1;
      end
   end

   // ************************************************************
   // Read data
   // ************************************************************

   reg  [15:0] exp_view;
   reg  [31:0] rd_d;

   // Expansion view; upper bits reserved and zero
   always @*
   begin
      exp_view = 16'h0000;
      exp_view[15:5] = 11'h000;
      exp_view[`ANP_EXP_PD_FAULT] = exp_flags[1];
      exp_view[`ANP_EXP_LP_NP] = lp_np_able;
      exp_view[`ANP_EXP_LOCAL_NP] = LOCAL_NP_ABLE;
      exp_view[`ANP_EXP_PAGE_RX] = exp_flags[0];
      // only meaningful while negotiation is enabled
      exp_view[`ANP_EXP_LP_AN] = an_enable & partner_negotiation_capable;
   end

   // Read multiplexer; unmapped words read as zero
   always @*
   begin
      rd_d = 32'h00000000;
      if (dp_map_q)
      begin
         case (dp_idx_q)
            `ANP_IDX_EXP:
            begin
               rd_d = {16'h0000, exp_view};
            end
            `ANP_IDX_NPTX:
            begin
               rd_d = {16'h0000, nptx_q};
            end
            `ANP_IDX_NPRX:
            begin
               rd_d = {16'h0000, nprx_q};
            end
            `ANP_IDX_IRQ_STAT:
            begin
               rd_d = {29'h00000000, irq_stat};
            end
            `ANP_IDX_IRQ_MASK:
            begin
               rd_d = {29'h00000000, mask_q};
            end
            default:
            begin
               rd_d = 32'h00000000;
            end
         endcase
      end
   end

   // Read data lands together with hready going high
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hrdata_q <= 32'h00000000;
      end
      else if (dp_q & ~dp_wr_q)
      begin
         hrdata_q <= rd_d;
      end
   end

   // ************************************************************
   // Expansion flags
   // ************************************************************

   wire [1:0] exp_set;
   wire [1:0] exp_clr;

   // delayed page strobe sets, read clears
   assign exp_set = {pd_fault_evt, page_dly_q};
   assign exp_clr = {2{do_rd & hit_exp}};

   anp_sticky #(.W(2)) u_exp_flags
   (
      .clk   (clk),
      .rst_b (rst_n),
      .set   (exp_set),
      .clr   (exp_clr),
      .flags (exp_flags)
   );

   // ************************************************************
   // Next-page transmit and receive
   // ************************************************************

   // Transmit page: software fields plus toggle kept by hardware
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         nptx_q <= `ANP_NPTX_RESET;
      end
      else
      begin
         if (do_wr & hit_tx)
         begin
            nptx_q <= (hwdata[15:0] & `ANP_NP_WMASK) | (nptx_q & ~`ANP_NP_WMASK);
         end
         if (page_rx_evt)
         begin
            nptx_q[`ANP_NP_TOGGLE] <= ~page_rx_word[`ANP_NP_TOGGLE];
         end
         nptx_q[`ANP_NP_RSVD] <= 1'b0;
      end
   end

   // Received page; the flag follows one cycle after the load
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         nprx_q     <= `ANP_NPRX_RESET;
         page_dly_q <= 1'b0;
      end
      else
      begin
         page_dly_q <= page_rx_evt;
         if (page_rx_evt)
         begin
            nprx_q <= {page_rx_word[`ANP_NP_MORE], 1'b0,
                       page_rx_word[`ANP_NP_MSG:`ANP_NP_COMPLY_ACKNOWLEDGE],
                       ~page_rx_word[`ANP_NP_TOGGLE],
                       page_rx_word[`ANP_NP_CODE_HI:0]};
         end
      end
   end

   // Pending flag: a new transmit page waits for the engine
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pend_q <= 1'b0;
      end
      else if (do_wr & hit_tx)
      begin
         pend_q <= 1'b1;
      end
      else if (tx_taken_evt)
      begin
         pend_q <= 1'b0;
      end
   end

   // ************************************************************
   // Interrupts
   // ************************************************************

   wire [`ANP_IRQ_W-1:0] irq_set;
   wire [`ANP_IRQ_W-1:0] irq_clr;

   assign irq_set = {tx_taken_evt, page_dly_q, pd_fault_evt};
   // Write one to clear; set still wins in the same cycle
   assign irq_clr = (do_wr & hit_irq) ? hwdata[`ANP_IRQ_W-1:0] : {`ANP_IRQ_W{1'b0}};

   anp_sticky #(.W(`ANP_IRQ_W)) u_irq_stat
   (
      .clk   (clk),
      .rst_b (rst_n),
      .set   (irq_set),
      .clr   (irq_clr),
      .flags (irq_stat)
   );

   // Mask register and registered interrupt level
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mask_q <= `ANP_IRQ_MASK_RESET;
         irq_q  <= 1'b0;
      end
      else
      begin
         if (do_wr & hit_mask)
         begin
            mask_q <= hwdata[`ANP_IRQ_W-1:0];
         end
         irq_q <= |(irq_stat & mask_q);
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************

   assign hreadyout    = hready_q;
   assign hrdata       = hrdata_q;
   assign hresp        = hresp_q;
   assign tx_page      = nptx_q;
   assign tx_page_pend = pend_q;
   assign irq          = irq_q;

endmodule // anp_regs

//--- hdl/anp_rst_sync.v
// Reset synchroniser: asynchronous assertion, release through two flip-flops
module anp_rst_sync
(
   input  wire clk,
   input  wire rst_b,
   output wire rst_sync_b
);

   reg meta_q;
   reg sync_q;

   // Only the second stage is used by the rest of the design
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end
      else
      begin
         meta_q <= 1'b1;
         sync_q <= meta_q;
      end
   end

   assign rst_sync_b = sync_q;

endmodule // anp_rst_sync

//--- hdl/anp_sticky.v
// Bank of sticky flags where a set in the same cycle as a clear wins
module anp_sticky
#(
   parameter W = 2
)
(
   input  wire         clk,
   input  wire         rst_b,
   input  wire [W-1:0] set,
   input  wire [W-1:0] clr,
   output wire [W-1:0] flags
);

   reg [W-1:0] flags_q;
   wire [W-1:0] flags_d;

   // Set has priority so an event in the clearing cycle is not lost
   assign flags_d = (flags_q & ~clr) | set;

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         flags_q <= {W{1'b0}};
      end
      else
      begin
         flags_q <= flags_d;
      end
   end

   assign flags = flags_q;

endmodule // anp_sticky
